// *** rtl/vps_sequencer.sv ***
// Supply-line protection switch sequencer top level
`timescale 1ns/1ps
`default_nettype none
module vps_sequencer
  import vps_pkg::*;
#(
  parameter int STARTUP_CYCLES_P = STARTUP_CYCLES,
  parameter int RECOVERY_CYCLES_P = RECOVERY_CYCLES,
  parameter int SOFT_START_CYCLES_P = SOFT_START_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic switch_req_n_in,
  input wire logic supply_too_low_level_in,
  input wire logic overvoltage_in,
  input wire logic thermal_trip_in,
  output logic pass_switch_on_out,
  output logic charge_pump_en_out,
  output logic soft_start_active_out,
  output logic status_out,
  output logic status_oe_out,
  output logic fault_out
);

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  logic rst_n;

  vps_reset_sync u_reset_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .rst_n_out(rst_n)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  vps_state_type state_q;
  vps_state_type state_d;
  logic switch_q;
  logic switch_d;
  logic pump_q;
  logic pump_d;
  logic ramp_q;
  logic ramp_d;
  logic status_low_q;
  logic status_low_d;
  logic fault_q;
  logic fault_d;
  logic ov_seen_q;
  logic ov_seen_d;

  logic delay_load;
  logic [TIMER_WIDTH-1:0] delay_count;
  logic delay_done;
  logic ramp_load;
  logic ramp_done;

  logic request_on;
  logic any_fault;

  assign request_on = !switch_req_n_in;
  assign any_fault = overvoltage_in || thermal_trip_in;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  vps_timer u_delay_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .load_in(delay_load),
    .count_in(delay_count),
    .done_out(delay_done)
  );

  vps_timer u_ramp_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .load_in(ramp_load),
    .count_in(TIMER_WIDTH'(SOFT_START_CYCLES_P)),
    .done_out(ramp_done)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ov_seen_d = ov_seen_q;
    delay_load = 1'b0;
    delay_count = TIMER_WIDTH'(STARTUP_CYCLES_P);
    ramp_load = 1'b0;
    if (overvoltage_in) begin
      ov_seen_d = 1'b1;
    end
    if (supply_too_low_level_in) begin
      state_d = VPS_UNPOWERED;
      ov_seen_d = 1'b0;
    end else if (any_fault) begin
      state_d = VPS_FAULT;
    end else if (!request_on) begin
      state_d = VPS_IDLE;
      ov_seen_d = 1'b0;
    end else begin
      case (state_q)
        VPS_UNPOWERED, VPS_IDLE: begin
          state_d = VPS_STARTUP;
          delay_load = 1'b1;
        end
        VPS_FAULT: begin
          // Comparator has cleared below threshold minus hysteresis
          if (ov_seen_q) begin
            state_d = VPS_RECOVERY;
            delay_count = TIMER_WIDTH'(RECOVERY_CYCLES_P);
          end else begin
            state_d = VPS_STARTUP;
          end
          delay_load = 1'b1;
          ov_seen_d = 1'b0;
        end
        VPS_STARTUP, VPS_RECOVERY: begin
          if (delay_done) begin
            state_d = VPS_SOFT_START;
            ramp_load = 1'b1;
          end
        end
        VPS_SOFT_START: begin
          if (ramp_done) begin
            state_d = VPS_ON;
          end
        end
        VPS_ON: begin
          state_d = VPS_ON;
        end
        default: begin
          state_d = VPS_UNPOWERED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  always_comb begin
    pump_d = (state_d == VPS_SOFT_START) || (state_d == VPS_ON);
    ramp_d = (state_d == VPS_SOFT_START);
    switch_d = (state_d == VPS_ON) || (state_d == VPS_SOFT_START);
    status_low_d = (state_d == VPS_ON);
    fault_d = (state_d == VPS_FAULT);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= VPS_UNPOWERED;
      ov_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ov_seen_q <= ov_seen_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pump_q <= 1'b0;
      ramp_q <= 1'b0;
      switch_q <= 1'b0;
      status_low_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      pump_q <= pump_d;
      ramp_q <= ramp_d;
      switch_q <= switch_d;
      status_low_q <= status_low_d;
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Overvoltage gates switch and pump directly, no clock latency
  assign pass_switch_on_out = switch_q && !overvoltage_in;
  assign charge_pump_en_out = pump_q && !overvoltage_in;
  assign soft_start_active_out = ramp_q && !overvoltage_in;
  // Open-drain: drive low only, release otherwise
  assign status_out = 1'b0;
  assign status_oe_out = status_low_q && !overvoltage_in;
  assign fault_out = fault_q;

endmodule
`default_nettype wire

// *** rtl/vps_pkg.sv ***
// Constants and types for the supply-line protection switch sequencer
package vps_pkg;

  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int STARTUP_DELAY_MS = 15;
  localparam int RECOVERY_DELAY_MS = 20;
  localparam int SOFT_START_MS = 25;
  localparam int OV_RESPONSE_NS = 100;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int STARTUP_CYCLES = STARTUP_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int RECOVERY_CYCLES = RECOVERY_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int SOFT_START_CYCLES = SOFT_START_MS * (CLK_FREQ_HZ / 1000);
  localparam int OV_RESPONSE_CYCLES = OV_RESPONSE_NS / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 32;
  localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

  typedef enum logic [2:0] {
    VPS_UNPOWERED,
    VPS_IDLE,
    VPS_STARTUP,
    VPS_RECOVERY,
    VPS_SOFT_START,
    VPS_ON,
    VPS_FAULT
  } vps_state_type;

endpackage

// *** rtl/vps_reset_sync.sv ***
// Two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module vps_reset_sync
  import vps_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  output logic rst_n_out
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d = {sync_q[0], 1'b1};
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_q <= RESET_SYNC_INIT;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign rst_n_out = sync_q[1];

endmodule
`default_nettype wire

// *** rtl/vps_timer.sv ***
// Down-counting interval timer with load and done flag
`timescale 1ns/1ps
`default_nettype none
module vps_timer
  import vps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [TIMER_WIDTH-1:0] count_in,
  output logic done_out
);

  logic [TIMER_WIDTH-1:0] count_q;
  logic [TIMER_WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (load_in) begin
      count_d = count_in;
    end else if (count_q != '0) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Last cycle of the loaded interval
  assign done_out = !load_in && (count_q == {{(TIMER_WIDTH-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

// *** verif/vps_sequencer_sva.sv ***
// Property checker for the protection switch sequencer
`timescale 1ns/1ps
`default_nettype none
module vps_sequencer_sva
  import vps_pkg::*;
#(
  parameter int STARTUP_CYCLES_P = STARTUP_CYCLES,
  parameter int RECOVERY_CYCLES_P = RECOVERY_CYCLES,
  parameter int SOFT_START_CYCLES_P = SOFT_START_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic switch_req_n_in,
  input wire logic supply_too_low_level_in,
  input wire logic overvoltage_in,
  input wire logic thermal_trip_in,
  input wire logic pass_switch_on_out,
  input wire logic charge_pump_en_out,
  input wire logic soft_start_active_out,
  input wire logic status_out,
  input wire logic status_oe_out,
  input wire logic fault_out
);
  logic [31:0] quiet_q, quiet_d, ramp_q, ramp_d;
  // ----------------------------------------
  // Cycles of calm request and of ramp
  // ----------------------------------------
  always_comb begin
    quiet_d = quiet_q + 32'h1;
    if (switch_req_n_in | supply_too_low_level_in | overvoltage_in | thermal_trip_in) begin
      quiet_d = 32'h0;
    end
    ramp_d = soft_start_active_out ? ramp_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      quiet_q <= 32'h0;
      ramp_q <= 32'h0;
    end else begin
      quiet_q <= quiet_d;
      ramp_q <= ramp_d;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_pump_up;
    $rose(charge_pump_en_out);
  endsequence
  property p_ov_cut;
    overvoltage_in |-> !(pass_switch_on_out | charge_pump_en_out | status_oe_out);
  endproperty
  a_ov_cut: assert property (p_ov_cut) else $error("switch on in overvoltage");
  property p_req_off;
    switch_req_n_in [*3] |-> !(pass_switch_on_out | status_oe_out);
  endproperty
  a_req_off: assert property (p_req_off) else $error("switch on without request");
  property p_uv_off;
    supply_too_low_level_in [*3] |-> !(pass_switch_on_out | status_oe_out);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("switch on in undervoltage");
  property p_th_off;
    thermal_trip_in ##1 thermal_trip_in ##1 thermal_trip_in |-> !pass_switch_on_out && !status_oe_out;
  endproperty
  a_th_off: assert property (p_th_off) else $error("switch on when hot");
  property p_ack_on;
    status_oe_out |-> pass_switch_on_out && !soft_start_active_out;
  endproperty
  a_ack_on: assert property (p_ack_on) else $error("status low while not fully on");
  property p_od;
    status_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("status driven high");
  property p_dly;
    s_pump_up |-> (quiet_q >= STARTUP_CYCLES_P && quiet_q <= STARTUP_CYCLES_P + 4) ||
      (quiet_q >= RECOVERY_CYCLES_P && quiet_q <= RECOVERY_CYCLES_P + 4);
  endproperty
  a_dly: assert property (p_dly) else $error("pump delay wrong");
  property p_ramp_up;
    s_pump_up |-> soft_start_active_out && pass_switch_on_out;
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("pump without ramp");
  property p_ss;
    $rose(status_oe_out) |-> ramp_q >= SOFT_START_CYCLES_P - 1 && ramp_q <= SOFT_START_CYCLES_P + 1;
  endproperty
  a_ss: assert property (p_ss) else $error("soft start length wrong");
endmodule
bind vps_sequencer vps_sequencer_sva #(.STARTUP_CYCLES_P(STARTUP_CYCLES_P),
  .RECOVERY_CYCLES_P(RECOVERY_CYCLES_P), .SOFT_START_CYCLES_P(SOFT_START_CYCLES_P)) i_sva (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .switch_req_n_in(switch_req_n_in),
  .supply_too_low_level_in(supply_too_low_level_in), .overvoltage_in(overvoltage_in),
  .thermal_trip_in(thermal_trip_in), .pass_switch_on_out(pass_switch_on_out),
  .charge_pump_en_out(charge_pump_en_out), .soft_start_active_out(soft_start_active_out),
  .status_out(status_out), .status_oe_out(status_oe_out), .fault_out(fault_out));
`default_nettype wire

// *** verif/vps_host_model.sv ***
// Host controller model: request line and pulled-up status wire
`timescale 1ns/1ps
`default_nettype none
module vps_host_model
  import vps_pkg::*;
(
  input wire logic want_on_in,
  input wire logic status_in,
  input wire logic status_oe_in,
  output logic switch_req_n_out,
  output logic status_line_out
);
  assign switch_req_n_out = !want_on_in;
  // External pull-up when released
  assign status_line_out = status_oe_in ? status_in : 1'b1;
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking testbench for the protection switch sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vps_pkg::*;
  localparam int SD = 20, RD = 30, SSD = 40;
  logic clk = 1'b0, arst_n = 1'b0, want = 1'b0, uv = 1'b0, ov = 1'b0, th = 1'b0;
  logic req_n, pass, pump, ramp, st, oe, flt, line;
  int n_errors = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  vps_sequencer #(.STARTUP_CYCLES_P(SD), .RECOVERY_CYCLES_P(RD), .SOFT_START_CYCLES_P(SSD))
    i_vps_sequencer (.clk_in(clk), .arst_n_in(arst_n), .switch_req_n_in(req_n),
    .supply_too_low_level_in(uv), .overvoltage_in(ov), .thermal_trip_in(th),
    .pass_switch_on_out(pass), .charge_pump_en_out(pump), .soft_start_active_out(ramp),
    .status_out(st), .status_oe_out(oe), .fault_out(flt));
  vps_host_model i_vps_host_model (.want_on_in(want), .status_in(st), .status_oe_in(oe),
    .switch_req_n_out(req_n), .status_line_out(line));
  task automatic final_report();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bits: switch, pump, ramp, status wire, fault
  task automatic chk_out(input logic [4:0] exp);
    n_checks++;
    if ({pass, pump, ramp, line, flt} !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, {pass, pump, ramp, line, flt}, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_on(input logic ack, output int n);
    n = 0;
    while (!(ack ? line === 1'b0 : pump === 1'b1)) begin
      @(negedge clk);
      n++;
      if (n > 500) begin
        n_errors++;
        final_report();
      end
    end
  endtask
  task automatic t_startup();
    int n;
    want = 1'b1;
    wait_on(1'b0, n);
    chk_cnt(n, SD + 1);
    chk_out(5'h1E);
    wait_on(1'b1, n);
    chk_cnt(n, SSD);
    chk_out(5'h18);
  endtask
  task automatic t_ov();
    int n;
    ov = 1'b1;
    #1 chk_out(5'h02);
    @(negedge clk);
    chk_out(5'h03);
    repeat (6) @(negedge clk);
    chk_out(5'h03);
    ov = 1'b0;
    wait_on(1'b0, n);
    chk_cnt(n, RD + 1);
    chk_out(5'h1E);
    wait_on(1'b1, n);
    chk_cnt(n, SSD);
  endtask
  task automatic t_abort();
    int n;
    want = 1'b0;
    repeat (3) @(negedge clk);
    chk_out(5'h02);
    want = 1'b1;
    repeat (10) @(negedge clk);
    th = 1'b1;
    repeat (3) @(negedge clk);
    chk_out(5'h03);
    th = 1'b0;
    wait_on(1'b0, n);
    chk_cnt(n, SD + 1);
  endtask
  task automatic t_uv();
    int n;
    uv = 1'b1;
    repeat (30) @(negedge clk);
    chk_out(5'h02);
    uv = 1'b0;
    wait_on(1'b0, n);
    chk_cnt(n, SD + 1);
    want = 1'b0;
    @(negedge clk);
    chk_out(5'h02);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_out(5'h02);
    t_startup();
    t_ov();
    t_abort();
    t_uv();
    final_report();
  end
endmodule
`default_nettype wire
